//--- hw/bfs_pkg.sv
`default_nettype none
package bfs_pkg;
  // =====================================================================
  // Register map (byte addresses, one aligned word each).
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PH_INIT_OFS = 8'h04;
  localparam logic [7:0] N_INIT_OFS = 8'h08;
  localparam logic [7:0] PH_HIGH_OFS = 8'h0C;
  localparam logic [7:0] N_HIGH_OFS = 8'h10;
  localparam logic [7:0] PH_LOW_OFS = 8'h14;
  localparam logic [7:0] N_LOW_OFS = 8'h18;
  localparam logic [7:0] EARLY_DLY_OFS = 8'h1C;
  localparam logic [7:0] MAIN_DLY_OFS = 8'h20;
  localparam logic [7:0] SLOW_DLY_OFS = 8'h24;
  localparam logic [7:0] LOW_DLY_OFS = 8'h28;
  localparam logic [7:0] HOLD_OFS = 8'h2C;
  localparam logic [7:0] STATUS_OFS = 8'h30;

  // =====================================================================
  // Control word bit positions.
  localparam int POLE_MODE_BIT = 0;
  localparam int CUR_CHECK_BIT = 1;
  localparam int LATCH_BIT = 2;
  localparam int EARLY_EN_BIT = 3;
  localparam int MAIN_EN_BIT = 4;
  localparam int SLOW_EN_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h3E;

  // =====================================================================
  // Defaults and timing.
  localparam logic [15:0] THRESH_RESET = 16'h0419;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam int CLK_HZ = 125000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int MAG_W = 16;

  typedef enum logic [0:0] {
    MODE_THREE = 1'b0,
    MODE_SINGLE = 1'b1
  } bfs_mode_type;

  typedef struct packed {
    logic [2:0] phase_over;
    logic neutral_over;
  } bfs_cmp_type;

  typedef struct packed {
    logic [2:0] retrip;
    logic trip;
    logic cancel_reclose;
    logic target;
    logic trip_led;
    logic [2:0] phase_led;
  } bfs_out_type;
endpackage : bfs_pkg
`default_nettype wire

//--- hw/bfs_top.sv
`default_nettype none
module bfs_top #(
  parameter int TICK_DIV = bfs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Protection operands (same clock)
  input wire logic THREE_POLE_START_SEL,
  input wire logic POLE_A_START_SEL,
  input wire logic POLE_B_START_SEL,
  input wire logic POLE_C_START_SEL,
  input wire logic BLOCK_IN,
  input wire logic EARLY_CONTACT_IN,
  input wire logic NORMAL_CONTACT_POLE_C_IN,
  input wire logic OUT_OF_SERVICE_IN,
  // Current magnitudes from the phasor estimator
  input wire logic [15:0] MAG_A,
  input wire logic [15:0] MAG_B,
  input wire logic [15:0] MAG_C,
  input wire logic [15:0] MAG_N,
  // Scheme outputs
  output logic [2:0] RETRIP_OUT,
  output logic FAILED_BREAKER_TRIP_OUT,
  output logic CANCEL_RECLOSE_OUT,
  output logic TARGET_OUT,
  output logic TRIP_LED_OUT,
  output logic [2:0] PHASE_LED_OUT,
  output logic [2:0] EARLY_OP_OUT,
  output logic [2:0] MAIN_OP_OUT,
  output logic [2:0] SLOW_OP_OUT
);

  // =====================================================================
  // Register file
  logic [5:0] ctrl_r;
  logic [15:0] ph_init_r, n_init_r, ph_high_r, n_high_r, ph_low_r, n_low_r;
  logic [15:0] early_dly_r, main_dly_r, slow_dly_r, low_dly_r, hold_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rd_nxt;
  logic sel_phase;
  logic single_mode;
  logic [15:0] hold_cnt_r;

  assign sel_phase = HSEL && HREADY && HTRANS[1];
  assign single_mode = ctrl_r[bfs_pkg::POLE_MODE_BIT] == bfs_pkg::MODE_SINGLE;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= sel_phase && HWRITE;
      wr_addr_r <= HADDR[7:0];
    end
  end

  // A write lands at the edge that ends its data phase, where HWDATA stands.
  // Unmapped offsets are dropped here and read back as zero below.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= bfs_pkg::CTRL_RESET;
      ph_init_r <= bfs_pkg::THRESH_RESET;
      n_init_r <= bfs_pkg::THRESH_RESET;
      ph_high_r <= bfs_pkg::THRESH_RESET;
      n_high_r <= bfs_pkg::THRESH_RESET;
      ph_low_r <= bfs_pkg::THRESH_RESET;
      n_low_r <= bfs_pkg::THRESH_RESET;
      early_dly_r <= bfs_pkg::DELAY_RESET;
      main_dly_r <= bfs_pkg::DELAY_RESET;
      slow_dly_r <= bfs_pkg::DELAY_RESET;
      low_dly_r <= bfs_pkg::DELAY_RESET;
      hold_r <= bfs_pkg::DELAY_RESET;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        bfs_pkg::CTRL_OFS: ctrl_r <= HWDATA[5:0];
        bfs_pkg::PH_INIT_OFS: ph_init_r <= HWDATA[15:0];
        bfs_pkg::N_INIT_OFS: n_init_r <= HWDATA[15:0];
        bfs_pkg::PH_HIGH_OFS: ph_high_r <= HWDATA[15:0];
        bfs_pkg::N_HIGH_OFS: n_high_r <= HWDATA[15:0];
        bfs_pkg::PH_LOW_OFS: ph_low_r <= HWDATA[15:0];
        bfs_pkg::N_LOW_OFS: n_low_r <= HWDATA[15:0];
        bfs_pkg::EARLY_DLY_OFS: early_dly_r <= HWDATA[15:0];
        bfs_pkg::MAIN_DLY_OFS: main_dly_r <= HWDATA[15:0];
        bfs_pkg::SLOW_DLY_OFS: slow_dly_r <= HWDATA[15:0];
        bfs_pkg::LOW_DLY_OFS: low_dly_r <= HWDATA[15:0];
        bfs_pkg::HOLD_OFS: hold_r <= HWDATA[15:0];
        default: ;
      endcase
    end
  end

  // =====================================================================
  // Millisecond tick shared by every timer.
  // The divider runs free, so a timer may start up to one tick late; that
  // error stays below the one-millisecond step of every delay setting.
  logic [31:0] div_r;
  logic tick_r;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_r <= 32'h0;
      tick_r <= 1'b0;
    end else if (div_r >= 32'(TICK_DIV - 1)) begin
      div_r <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // =====================================================================
  // Current comparators with common settings for all poles.
  // The magnitude inputs are the estimator's; after interruption they ramp
  // to zero within a power cycle, so every comparator below lags by that.
  bfs_pkg::bfs_cmp_type init_cmp, high_cmp, low_cmp;
  logic [2:0] init_ok, out_high, out_low;

  // Comparisons are strict, so a magnitude equal to a threshold does not pick up.
  function automatic logic [2:0] over3(input logic [15:0] th);
    over3 = {MAG_C > th, MAG_B > th, MAG_A > th};
  endfunction : over3

  // A pole sees its own phase in single-pole mode, and any phase or the
  // neutral when all poles trip together.
  function automatic logic pole_current(input bfs_pkg::bfs_cmp_type cmp, input logic single, input int idx);
    if (single) begin
      pole_current = cmp.phase_over[idx];
    end else begin
      pole_current = (|cmp.phase_over) || cmp.neutral_over;
    end
  endfunction : pole_current

  always_comb begin
    init_cmp.phase_over = over3(ph_init_r);
    init_cmp.neutral_over = !single_mode && (MAG_N > n_init_r);
    high_cmp.phase_over = over3(ph_high_r);
    high_cmp.neutral_over = !single_mode && (MAG_N > n_high_r);
    low_cmp.phase_over = over3(ph_low_r);
    low_cmp.neutral_over = !single_mode && (MAG_N > n_low_r);
  end

  // =====================================================================
  // Initiation, seal-in and re-trip.
  logic [2:0] start_raw, start_ok, seal_r, init_act;
  logic [2:0] contact;
  logic three_start;

  assign three_start = !single_mode && THREE_POLE_START_SEL;
  assign start_raw = single_mode ? {POLE_C_START_SEL, POLE_B_START_SEL, POLE_A_START_SEL}
                                 : {3{three_start}};
  // Early contact: whole breaker in three-pole, poles A and B in single-pole.
  assign contact[0] = EARLY_CONTACT_IN;
  // Pole B has no contact of its own, so it shares the early contact in both modes.
  assign contact[1] = EARLY_CONTACT_IN;
  assign contact[2] = single_mode ? NORMAL_CONTACT_POLE_C_IN : EARLY_CONTACT_IN;

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_pole
      logic cur_p;
      logic t1_r, t2_r, t3_r, hi_en_r, lo_en_r;
      logic [15:0] c1_r, c2_r, c3_r, cl_r;
      logic high_ok, low_ok;
      // Neutral adds sensitivity only when all poles run together.
      assign cur_p = pole_current(init_cmp, single_mode, p);
      assign start_ok[p] = start_raw[p] && (!ctrl_r[bfs_pkg::CUR_CHECK_BIT] || cur_p);
      // The block input overrides both a fresh start and the seal-in.
      assign init_act[p] = !BLOCK_IN && (start_ok[p] || seal_r[p]);

      // The seal-in needs current even with the check off, so it clears once
      // the breaker interrupts the fault.
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          seal_r[p] <= 1'b0;
        end else begin
          seal_r[p] <= ctrl_r[bfs_pkg::LATCH_BIT] && !BLOCK_IN && cur_p && (start_ok[p] || seal_r[p]);
        end
      end

      // Path timers count ticks while initiated; drop synchronously otherwise.
      // Counts saturate, so a long initiation cannot wrap a timer below its delay.
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          c1_r <= 16'h0;
          c2_r <= 16'h0;
          c3_r <= 16'h0;
          t1_r <= 1'b0;
          t2_r <= 1'b0;
          t3_r <= 1'b0;
        end else if (!init_act[p]) begin
          c1_r <= 16'h0;
          c2_r <= 16'h0;
          c3_r <= 16'h0;
          t1_r <= 1'b0;
          t2_r <= 1'b0;
          t3_r <= 1'b0;
        end else begin
          t1_r <= t1_r || c1_r >= early_dly_r;
          t2_r <= t2_r || c2_r >= main_dly_r;
          t3_r <= t3_r || c3_r >= slow_dly_r;
          if (tick_r && c1_r != 16'hFFFF) c1_r <= c1_r + 16'h1;
          if (tick_r && c2_r != 16'hFFFF) c2_r <= c2_r + 16'h1;
          if (tick_r && c3_r != 16'hFFFF) c3_r <= c3_r + 16'h1;
        end
      end

      // High-set armed by timer 1 or 2 timeout, low-set after its own delay.
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          hi_en_r <= 1'b0;
          lo_en_r <= 1'b0;
          cl_r <= 16'h0;
        end else if (!init_act[p] || !((t1_r && ctrl_r[bfs_pkg::EARLY_EN_BIT]) ||
                                       (t2_r && ctrl_r[bfs_pkg::MAIN_EN_BIT]))) begin
          hi_en_r <= 1'b0;
          lo_en_r <= 1'b0;
          cl_r <= 16'h0;
        end else begin
          hi_en_r <= 1'b1;
          lo_en_r <= lo_en_r || cl_r >= low_dly_r;
          if (tick_r && cl_r != 16'hFFFF) cl_r <= cl_r + 16'h1;
        end
      end

      assign high_ok = hi_en_r && pole_current(high_cmp, single_mode, p);
      assign low_ok = lo_en_r && pole_current(low_cmp, single_mode, p);

      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          EARLY_OP_OUT[p] <= 1'b0;
          MAIN_OP_OUT[p] <= 1'b0;
          SLOW_OP_OUT[p] <= 1'b0;
        end else begin
          EARLY_OP_OUT[p] <= ctrl_r[bfs_pkg::EARLY_EN_BIT] && t1_r && init_act[p] &&
                             contact[p] && (high_ok || low_ok);
          MAIN_OP_OUT[p] <= ctrl_r[bfs_pkg::MAIN_EN_BIT] && t2_r && init_act[p] && (high_ok || low_ok);
          SLOW_OP_OUT[p] <= ctrl_r[bfs_pkg::SLOW_EN_BIT] && t3_r && init_act[p] &&
                            contact[p] && !OUT_OF_SERVICE_IN;
        end
      end
    end
  endgenerate

  // =====================================================================
  // Declaration, hold and indications.
  logic [2:0] op_now;
  logic declare;
  logic [2:0] phase_seen_r;
  assign op_now = EARLY_OP_OUT | MAIN_OP_OUT | SLOW_OP_OUT;
  assign declare = |op_now;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RETRIP_OUT <= 3'h0;
    end else begin
      RETRIP_OUT <= init_act;
    end
  end

  // The hold counter restarts on every operating cycle, so the trip lasts
  // the dropout period after the last declaring condition clears.
  // Declaring wins over the dropout count when both fall in one cycle.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_cnt_r <= 16'h0;
      FAILED_BREAKER_TRIP_OUT <= 1'b0;
      CANCEL_RECLOSE_OUT <= 1'b0;
      TARGET_OUT <= 1'b0;
      TRIP_LED_OUT <= 1'b0;
      phase_seen_r <= 3'h0;
      PHASE_LED_OUT <= 3'h0;
    end else if (declare) begin
      hold_cnt_r <= 16'h0;
      FAILED_BREAKER_TRIP_OUT <= 1'b1;
      CANCEL_RECLOSE_OUT <= 1'b1;
      TARGET_OUT <= 1'b1;
      TRIP_LED_OUT <= 1'b1;
      phase_seen_r <= phase_seen_r | op_now;
      PHASE_LED_OUT <= single_mode ? (phase_seen_r | op_now) : 3'h0;
    end else if (FAILED_BREAKER_TRIP_OUT) begin
      if (hold_cnt_r >= hold_r) begin
        FAILED_BREAKER_TRIP_OUT <= 1'b0;
        CANCEL_RECLOSE_OUT <= 1'b0;
        TARGET_OUT <= 1'b0;
        TRIP_LED_OUT <= 1'b0;
        phase_seen_r <= 3'h0;
        PHASE_LED_OUT <= 3'h0;
      end else if (tick_r) begin
        hold_cnt_r <= hold_cnt_r + 16'h1;
      end
    end
  end

  // =====================================================================
  // Read path, registered in the data phase with no wait states.
  always_comb begin
    rd_nxt = 32'h0;
    case (HADDR[7:0])
      bfs_pkg::CTRL_OFS: rd_nxt = {26'h0, ctrl_r};
      bfs_pkg::PH_INIT_OFS: rd_nxt = {16'h0, ph_init_r};
      bfs_pkg::N_INIT_OFS: rd_nxt = {16'h0, n_init_r};
      bfs_pkg::PH_HIGH_OFS: rd_nxt = {16'h0, ph_high_r};
      bfs_pkg::N_HIGH_OFS: rd_nxt = {16'h0, n_high_r};
      bfs_pkg::PH_LOW_OFS: rd_nxt = {16'h0, ph_low_r};
      bfs_pkg::N_LOW_OFS: rd_nxt = {16'h0, n_low_r};
      bfs_pkg::EARLY_DLY_OFS: rd_nxt = {16'h0, early_dly_r};
      bfs_pkg::MAIN_DLY_OFS: rd_nxt = {16'h0, main_dly_r};
      bfs_pkg::SLOW_DLY_OFS: rd_nxt = {16'h0, slow_dly_r};
      bfs_pkg::LOW_DLY_OFS: rd_nxt = {16'h0, low_dly_r};
      bfs_pkg::HOLD_OFS: rd_nxt = {16'h0, hold_r};
      // Status: trip, cancel, re-trip, seal, then early, main and slow per pole.
      bfs_pkg::STATUS_OFS: rd_nxt = {15'h0, SLOW_OP_OUT, MAIN_OP_OUT, EARLY_OP_OUT, seal_r, RETRIP_OUT,
                                     CANCEL_RECLOSE_OUT, FAILED_BREAKER_TRIP_OUT};
      default: rd_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      HRDATA <= 32'h0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (sel_phase && !HWRITE) HRDATA <= rd_nxt;
    end
  end

endmodule : bfs_top
`default_nettype wire

//--- verif/bfs_breaker_model.sv
`default_nettype none
module bfs_breaker_model #(
  parameter int OPEN_CYC = 4,
  parameter logic [15:0] FLT_MAG = 16'h0800
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench controls
  input wire logic [3:0] fault,
  input wire logic stuck,
  // Commands from the scheme
  input wire logic [2:0] retrip,
  input wire logic trip,
  // Currents and contacts
  output logic [15:0] mag_a,
  output logic [15:0] mag_b,
  output logic [15:0] mag_c,
  output logic [15:0] mag_n,
  output logic early_contact,
  output logic pole_c_contact
);
  wire logic [2:0] shut;
  wire logic [2:0] flow;
  // ==========
  // Poles
  for (genvar p = 0; p < 3; p++) begin : g_pole
    logic [3:0] cnt_r;
    logic open_r;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_r <= 4'h0;
        open_r <= 1'b0;
      end else if (fault == 4'h0) begin
        cnt_r <= 4'h0;
        open_r <= 1'b0;
      end else if (!(retrip[p] || trip)) begin
        // An opened pole stays open when the command drops; only clearing the fault recloses it.
        cnt_r <= 4'h0;
      end else if (!stuck && cnt_r == 4'(OPEN_CYC)) begin
        open_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
    assign shut[p] = open_r;
    assign flow[p] = fault[p] && !open_r;
  end
  assign early_contact = !shut[0];
  assign pole_c_contact = !shut[2];
  // ==========
  // Magnitudes
  // The estimate trails the interruption by one clock, so supervision sees a short lag.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {mag_a, mag_b, mag_c, mag_n} <= 64'h0;
    end else begin
      mag_a <= flow[0] ? FLT_MAG : 16'h0000;
      mag_b <= flow[1] ? FLT_MAG : 16'h0000;
      mag_c <= flow[2] ? FLT_MAG : 16'h0000;
      mag_n <= (fault[3] && !(&shut)) ? FLT_MAG : 16'h0000;
    end
  end
endmodule : bfs_breaker_model
`default_nettype wire

//--- verif/bfs_top_assertions.sv
`default_nettype none
module bfs_top_assertions (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Operands
  input wire logic THREE_POLE_START_SEL,
  input wire logic POLE_A_START_SEL,
  input wire logic POLE_B_START_SEL,
  input wire logic POLE_C_START_SEL,
  input wire logic BLOCK_IN,
  input wire logic EARLY_CONTACT_IN,
  input wire logic OUT_OF_SERVICE_IN,
  // Scheme outputs
  input wire logic [2:0] RETRIP_OUT,
  input wire logic FAILED_BREAKER_TRIP_OUT,
  input wire logic CANCEL_RECLOSE_OUT,
  input wire logic TARGET_OUT,
  input wire logic TRIP_LED_OUT,
  input wire logic [2:0] EARLY_OP_OUT,
  input wire logic [2:0] MAIN_OP_OUT,
  input wire logic [2:0] SLOW_OP_OUT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  logic any_op;
  assign any_op = |{EARLY_OP_OUT, MAIN_OP_OUT, SLOW_OP_OUT};
  // ==========
  // Trip sequencing
  sequence s_op_seen;
    any_op;
  endsequence
  sequence s_trip_rise;
    !FAILED_BREAKER_TRIP_OUT ##1 FAILED_BREAKER_TRIP_OUT;
  endsequence
  a_op_trips: assert property (s_op_seen |=> FAILED_BREAKER_TRIP_OUT)
    else $error("trip missing after a path operated");
  a_trip_cause: assert property (s_trip_rise |-> $past(any_op))
    else $error("trip raised with no path operated");
  a_trip_hold: assert property ($fell(FAILED_BREAKER_TRIP_OUT) |-> !$past(any_op))
    else $error("trip dropped while a path operated");
  a_cancel_trip: assert property (CANCEL_RECLOSE_OUT == FAILED_BREAKER_TRIP_OUT)
    else $error("cancel reclose differs from trip");
  a_trip_indicators: assert property (TARGET_OUT == FAILED_BREAKER_TRIP_OUT && TRIP_LED_OUT == TARGET_OUT)
    else $error("indicators differ from trip");
  // ==========
  // Initiation and supervision
  a_block_quiet: assert property ($past(BLOCK_IN) |-> RETRIP_OUT == 3'h0)
    else $error("retrip while blocked");
  a_retrip_cause: assert property ($rose(|RETRIP_OUT) |->
    $past(THREE_POLE_START_SEL | POLE_A_START_SEL | POLE_B_START_SEL | POLE_C_START_SEL))
    else $error("retrip without any initiate");
  a_slow_service: assert property ($past(OUT_OF_SERVICE_IN) && $past(OUT_OF_SERVICE_IN, 2) |->
    SLOW_OP_OUT == 3'h0)
    else $error("slow path operated out of service");
  a_early_contact: assert property (!$past(EARLY_CONTACT_IN) && !$past(EARLY_CONTACT_IN, 2) |->
    !EARLY_OP_OUT[0])
    else $error("early path operated with contact open");
endmodule : bfs_top_assertions
bind bfs_top bfs_top_assertions bfs_top_assertions_i (.CLK(CLK), .RST_N(RST_N),
  .THREE_POLE_START_SEL(THREE_POLE_START_SEL), .POLE_A_START_SEL(POLE_A_START_SEL),
  .POLE_B_START_SEL(POLE_B_START_SEL), .POLE_C_START_SEL(POLE_C_START_SEL), .BLOCK_IN(BLOCK_IN),
  .EARLY_CONTACT_IN(EARLY_CONTACT_IN), .OUT_OF_SERVICE_IN(OUT_OF_SERVICE_IN), .RETRIP_OUT(RETRIP_OUT),
  .FAILED_BREAKER_TRIP_OUT(FAILED_BREAKER_TRIP_OUT), .CANCEL_RECLOSE_OUT(CANCEL_RECLOSE_OUT),
  .TARGET_OUT(TARGET_OUT), .TRIP_LED_OUT(TRIP_LED_OUT), .EARLY_OP_OUT(EARLY_OP_OUT),
  .MAIN_OP_OUT(MAIN_OP_OUT), .SLOW_OP_OUT(SLOW_OP_OUT));
`default_nettype wire

//--- verif/bfs_top_tb.sv
`default_nettype none
module bfs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 6000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  logic [3:0] st_v = 4'h0;
  logic [3:0] fault_v = 4'h0;
  logic stuck = 1'b0;
  logic blk = 1'b0;
  logic oos = 1'b0;
  logic [15:0] mag_a, mag_b, mag_c, mag_n;
  logic early_c, pole_c;
  logic [2:0] retrip, phase_led, early_op, main_op, slow_op;
  logic trip, cancel, target, trip_led;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  bfs_top #(.TICK_DIV(10)) bfs_top_i (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .THREE_POLE_START_SEL(st_v[3]), .POLE_A_START_SEL(st_v[2]),
    .POLE_B_START_SEL(st_v[1]), .POLE_C_START_SEL(st_v[0]), .BLOCK_IN(blk), .EARLY_CONTACT_IN(early_c),
    .NORMAL_CONTACT_POLE_C_IN(pole_c), .OUT_OF_SERVICE_IN(oos), .MAG_A(mag_a), .MAG_B(mag_b),
    .MAG_C(mag_c), .MAG_N(mag_n), .RETRIP_OUT(retrip), .FAILED_BREAKER_TRIP_OUT(trip),
    .CANCEL_RECLOSE_OUT(cancel), .TARGET_OUT(target), .TRIP_LED_OUT(trip_led), .PHASE_LED_OUT(phase_led),
    .EARLY_OP_OUT(early_op), .MAIN_OP_OUT(main_op), .SLOW_OP_OUT(slow_op));
  bfs_breaker_model bfs_breaker_model_i (.clk(clk), .rst_n(rst_n), .fault(fault_v), .stuck(stuck),
    .retrip(retrip), .trip(trip), .mag_a(mag_a), .mag_b(mag_b), .mag_c(mag_c), .mag_n(mag_n),
    .early_contact(early_c), .pole_c_contact(pole_c));
  // ==========
  // Tasks
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    chk("register", e, rd);
  endtask : rdchk
  task automatic go(input logic [5:0] ctl, input logic [3:0] f, input logic s, input logic [3:0] st, input int n);
    logic [31:0] rd;
    bus(1'b1, bfs_pkg::CTRL_OFS, {26'h0, ctl}, rd);
    @(posedge clk);
    fault_v <= f;
    stuck <= s;
    st_v <= st;
    repeat (n) @(posedge clk);
  endtask : go
  task automatic idle;
    @(posedge clk);
    fault_v <= 4'h0;
    st_v <= 4'h0;
    blk <= 1'b0;
    oos <= 1'b0;
    repeat (120) @(posedge clk);
  endtask : idle
  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      final_report();
    end
  end
  // ==========
  // Sequence
  initial begin
    logic [31:0] rd;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      rdchk(8'(4 * i), i == 0 ? 32'h3E : (i < 7 ? 32'h419 : 32'h0));
    end
    bus(1'b1, 8'h40, 32'hFFFF_FFFF, rd);
    rdchk(8'h40, 32'h0);
    bus(1'b1, bfs_pkg::EARLY_DLY_OFS, 32'hFFFF, rd);
    rdchk(bfs_pkg::EARLY_DLY_OFS, 32'hFFFF);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 8'(bfs_pkg::EARLY_DLY_OFS + 4 * i), 32'(i + 2), rd);
    end
    go(6'h3E, 4'h7, 1'b1, 4'h8, 3);
    chk("retrip", 32'h7, 32'(retrip));
    chk("trip", 32'h0, 32'(trip));
    repeat (40) @(posedge clk);
    chk("trip", 32'h1, 32'(trip));
    chk("cancel", 32'h1, 32'(cancel));
    chk("target", 32'h1, 32'(target));
    chk("trip led", 32'h1, 32'(trip_led));
    chk("early", 32'h7, 32'(early_op));
    bus(1'b0, bfs_pkg::STATUS_OFS, 32'h0, rd);
    chk("status", 32'h1F, rd & 32'h1F);
    chk("response", 32'h0, 32'(hresp));
    st_v <= 4'h0;
    repeat (4) @(posedge clk);
    chk("retrip", 32'h7, 32'(retrip));
    fault_v <= 4'h0;
    repeat (8) @(posedge clk);
    chk("retrip", 32'h0, 32'(retrip));
    repeat (20) @(posedge clk);
    chk("trip", 32'h1, 32'(trip));
    repeat (60) @(posedge clk);
    chk("trip", 32'h0, 32'(trip));
    idle();
    for (int p = 0; p < 3; p++) begin
      go(6'(8 << p), 4'h7, 1'b1, 4'h8, 80);
      chk("early", p == 0 ? 32'h7 : 32'h0, 32'(early_op));
      chk("main", p == 1 ? 32'h7 : 32'h0, 32'(main_op));
      chk("slow", p == 2 ? 32'h7 : 32'h0, 32'(slow_op));
      idle();
    end
    oos <= 1'b1;
    go(6'h20, 4'h0, 1'b1, 4'h8, 80);
    chk("slow", 32'h0, 32'(slow_op));
    oos <= 1'b0;
    repeat (10) @(posedge clk);
    chk("slow", 32'h7, 32'(slow_op));
    idle();
    go(6'h3E, 4'h7, 1'b0, 4'h8, 100);
    chk("trip", 32'h0, 32'(trip));
    chk("retrip", 32'h0, 32'(retrip));
    idle();
    go(6'h02, 4'h0, 1'b1, 4'h8, 4);
    chk("retrip", 32'h0, 32'(retrip));
    go(6'h00, 4'h0, 1'b1, 4'h8, 4);
    chk("retrip", 32'h7, 32'(retrip));
    idle();
    go(6'h02, 4'h8, 1'b1, 4'h8, 4);
    chk("retrip", 32'h7, 32'(retrip));
    go(6'h03, 4'h8, 1'b1, 4'h4, 4);
    chk("retrip", 32'h0, 32'(retrip));
    idle();
    for (int p = 0; p < 3; p++) begin
      go(6'h3F, 4'(1 << p), 1'b1, 4'(4 >> p), 60);
      chk("retrip", 32'(1 << p), 32'(retrip));
      chk("phase led", 32'(1 << p), 32'(phase_led));
      idle();
    end
    blk <= 1'b1;
    go(6'h3C, 4'h7, 1'b1, 4'h8, 60);
    chk("retrip", 32'h0, 32'(retrip));
    chk("trip", 32'h0, 32'(trip));
    idle();
    bus(1'b1, bfs_pkg::PH_HIGH_OFS, 32'hFFFF, rd);
    go(6'h10, 4'h7, 1'b1, 4'h8, 40);
    chk("main", 32'h0, 32'(main_op));
    repeat (80) @(posedge clk);
    chk("main", 32'h7, 32'(main_op));
    idle();
    final_report();
  end
endmodule : bfs_top_tb
`default_nettype wire
